/* design/dtrcp_map.svh */
/*
 Register offsets, field masks, reset values and mode codes of the dual
 timer. Included by the package; it assumes nothing of its surroundings.
*/
`ifndef DTRCP_MAP_SVH
`define DTRCP_MAP_SVH

`define DTRCP_ADDR_W 8
`define DTRCP_DATA_W 32
`define DTRCP_CNT_W 16
`define DTRCP_PRE_W 8
`define DTRCP_CFG_W 3
`define DTRCP_DIV_W 16

`define DTRCP_CNT_RST 16'hFFFF
`define DTRCP_PRE_RST 8'h00
`define DTRCP_RTC_PRELOAD 32'h0000_0001
`define DTRCP_RTC_DIV 32768

`define DTRCP_CFG_32 3'h0
`define DTRCP_CFG_RTC 3'h1
`define DTRCP_CFG_16 3'h4

`define DTRCP_TMR_ONESHOT 2'h1
`define DTRCP_TMR_PERIODIC 2'h2
`define DTRCP_TMR_CAPTURE 2'h3

`define DTRCP_EVT_POS 2'h0
`define DTRCP_EVT_NEG 2'h1

`define DTRCP_CTL_MASK 16'h6F7F
`define DTRCP_STAT_MASK 8'h0F
`define DTRCP_MODE_MASK 8'h0F

`define DTRCP_A_CFG 8'h00
`define DTRCP_A_MODE_A 8'h04
`define DTRCP_A_MODE_B 8'h08
`define DTRCP_A_CTL 8'h0C
`define DTRCP_A_IMR 8'h18
`define DTRCP_A_RIS 8'h1C
`define DTRCP_A_MIS 8'h20
`define DTRCP_A_ICR 8'h24
`define DTRCP_A_ILR_A 8'h28
`define DTRCP_A_ILR_B 8'h2C
`define DTRCP_A_MATCH_A 8'h30
`define DTRCP_A_MATCH_B 8'h34
`define DTRCP_A_PR_A 8'h38
`define DTRCP_A_PR_B 8'h3C
`define DTRCP_A_VAL_A 8'h48
`define DTRCP_A_VAL_B 8'h4C

`endif

/* design/dtrcp_pkg.sv */
/*
 Types of the dual timer: control, mode and status layouts and the whole
 state of the timer as one packed struct. Assumes the map header is on
 the include path.
*/
`include "dtrcp_map.svh"

package dtrcp_pkg;

    typedef logic [`DTRCP_CNT_W-1:0] dtrcp_cnt_t;
    typedef logic [`DTRCP_PRE_W-1:0] dtrcp_pre_t;

    typedef struct packed {
        logic rsv;
        logic pwm_invert_bit;
        logic adc_trigger_enable;
        logic rtc_run_in_debug_bit;
        logic [1:0] event_sel;
        logic debug_stall_bit;
        logic counter_enable;
    } dtrcp_ctl_t;

    typedef struct packed {
        logic [3:0] rsv;
        logic alternate_mode_select;
        logic capture_mode_bit;
        logic [1:0] timer_mode_field;
    } dtrcp_mode_t;

    typedef struct packed {
        logic [3:0] rsv;
        logic rtc_flag;
        logic capture_event_flag;
        logic count_match_flag;
        logic timeout_flag;
    } dtrcp_stat_t;

    typedef struct packed {
        logic [`DTRCP_CFG_W-1:0] config_reg;
        dtrcp_mode_t [1:0] counter_mode_reg;
        dtrcp_ctl_t [1:0] control_reg;
        dtrcp_stat_t [1:0] interrupt_mask_reg;
        dtrcp_stat_t [1:0] raw_status_reg;
        dtrcp_cnt_t [1:0] interval_load_reg;
        dtrcp_cnt_t [1:0] counter_match_reg;
        dtrcp_pre_t [1:0] prescale_reg;
        dtrcp_cnt_t [1:0] cnt;
        dtrcp_pre_t [1:0] ps;
        dtrcp_cnt_t [1:0] captured_value_reg;
        logic rtc_seen;
        logic [`DTRCP_DIV_W-1:0] div;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [1:0] pwm;
        logic [1:0] pin_out;
        logic [1:0] pin_oe_n;
        logic [1:0] adc_trig;
        logic irq;
        logic [`DTRCP_DATA_W-1:0] rdata;
    } dtrcp_state_t;

    localparam dtrcp_state_t DTRCP_RST = '{
        interval_load_reg: {2{`DTRCP_CNT_RST}},
        cnt: {2{`DTRCP_CNT_RST}},
        prescale_reg: {2{`DTRCP_PRE_RST}},
        ps: {2{`DTRCP_PRE_RST}},
        pin_oe_n: 2'h3,
        default: '0
    };

endpackage : dtrcp_pkg

/* design/dtrcp_timer.sv */
/*
 Dual 16-bit timer with a joined 32-bit real-time-clock mode, one-shot and
 periodic counting with prescaler, edge count, edge time capture and PWM.
 Assumes a register master on core_clk that never waits, a debug halt
 level from logic on the same clock, and capture pins from outside.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps

// Operation
// - Real-time-clock mode joins both counters into one 32-bit up-counter.
// - First selection of clock mode preloads the 32-bit count with one.
// - A 32.768 kHz clock on the even pin is divided to a 1 Hz tick.
// - On a clock match the count rolls to zero and keeps counting.
// - A clock match sets the raw flag, masked flag if enabled; clear bit clears.
// - With run-in-debug set the clock keeps counting during a debugger halt.
// - Configuration value four selects independent 16-bit counters.
// - One-shot and periodic counters count down with an 8-bit prescaler.
// - At zero the counter reloads; one-shot stops and clears its enable.
// - Time-out sets a sticky flag, masked flag if enabled, optional ADC trigger.
// - A new interval load while running is taken on the next cycle.
// - With its stall bit set a counter freezes during a debugger halt.
// - Prescale value p makes each decrement take p+1 clock periods.
// - The prescaler is bypassed in edge count, edge time and PWM modes.
// - Edge count mode decrements once per selected edge until the match.
// - At the match: flags set, reload, enable cleared, further edges ignored.
// - Edge time mode captures the running count on each selected edge.
// - Edge time counting continues after capture and reloads at zero.
// - PWM counts down, reloads at zero, and raises no flags.
module dtrcp_timer
    import dtrcp_pkg::*;
#(
    parameter int RTC_DIV = `DTRCP_RTC_DIV
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [`DTRCP_ADDR_W-1:0] addr,
    input wire logic [`DTRCP_DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [`DTRCP_DATA_W-1:0] rdata,
    // Debug.
    input wire logic dbg_halt,
    // Capture compare pins.
    input wire logic [1:0] capture_compare_pin_in,
    output logic [1:0] capture_compare_pin_out,
    output logic [1:0] capture_compare_pin_oe_n,
    // Events.
    output logic irq,
    output logic [1:0] adc_trig
);

    localparam logic [`DTRCP_DIV_W-1:0] DIV_LAST = `DTRCP_DIV_W'(RTC_DIV - 1);

    // A divider below two would tick on every edge and the last-count compare would never settle.
    if (RTC_DIV < 2 || RTC_DIV > (1 << `DTRCP_DIV_W))
    begin : g_bad_div
        $error("RTC_DIV out of range");
    end

    function automatic logic dtrcp_edge(input logic [1:0] sel, input logic cur,
                                        input logic old);
        if (sel == `DTRCP_EVT_POS)
            return cur & ~old;
        else if (sel == `DTRCP_EVT_NEG)
            return ~cur & old;
        else
            return cur ^ old;
    endfunction : dtrcp_edge

    dtrcp_state_t r;
    dtrcp_state_t next_r;
    logic [1:0] ev;
    logic rtc_tick;
    logic rtc_frozen;
    logic [1:0] is_timer;
    logic [1:0] is_ecnt;
    logic [1:0] is_etime;
    logic [1:0] is_pwm;
    logic [1:0] run;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            ev[i] = dtrcp_edge(r.control_reg[i].event_sel, r.sync2[i], r.prev[i]);
            is_timer[i] = !r.counter_mode_reg[i].alternate_mode_select &&
                (r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_ONESHOT ||
                 r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_PERIODIC);
            is_ecnt[i] = !r.counter_mode_reg[i].alternate_mode_select &&
                r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_CAPTURE &&
                !r.counter_mode_reg[i].capture_mode_bit;
            is_etime[i] = !r.counter_mode_reg[i].alternate_mode_select &&
                r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_CAPTURE &&
                r.counter_mode_reg[i].capture_mode_bit;
            is_pwm[i] = r.counter_mode_reg[i].alternate_mode_select &&
                !r.counter_mode_reg[i].capture_mode_bit &&
                r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_PERIODIC;
            run[i] = r.control_reg[i].counter_enable &&
                !(dbg_halt && r.control_reg[i].debug_stall_bit);
        end
        rtc_frozen = dbg_halt && !r.control_reg[0].rtc_run_in_debug_bit &&
            (r.control_reg[0].debug_stall_bit || r.control_reg[1].debug_stall_bit);
        rtc_tick = r.config_reg == `DTRCP_CFG_RTC && r.control_reg[0].counter_enable &&
            !rtc_frozen && r.div == DIV_LAST &&
            dtrcp_edge(`DTRCP_EVT_POS, r.sync2[0], r.prev[0]);
    end

    always_comb
    begin
        dtrcp_stat_t [1:0] set_f;
        dtrcp_stat_t [1:0] clr_f;
        logic [1:0] ilr_wr;
        dtrcp_cnt_t dec;
        set_f = '0;
        clr_f = '0;
        ilr_wr = '0;
        dec = '0;
        next_r = r;
        next_r.adc_trig = '0;
        next_r.rdata = '0;
        // The first stage feeds only the second; edges come from stage two.
        next_r.sync1 = capture_compare_pin_in;
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;

        if (wr_stb)
        begin
            ilr_wr[0] = addr == `DTRCP_A_ILR_A;
            ilr_wr[1] = addr == `DTRCP_A_ILR_B;
        end

        if (r.config_reg == `DTRCP_CFG_RTC)
        begin
            if (r.control_reg[0].counter_enable && !rtc_frozen &&
                dtrcp_edge(`DTRCP_EVT_POS, r.sync2[0], r.prev[0]))
            begin
                next_r.div = (r.div == DIV_LAST) ? '0 : r.div + 1'b1;
            end
            if (rtc_tick)
            begin
                if (r.cnt == r.counter_match_reg)
                begin
                    next_r.cnt = '0;
                    set_f[0].rtc_flag = 1'b1;
                end
                else
                begin
                    next_r.cnt = r.cnt + `DTRCP_RTC_PRELOAD;
                end
            end
        end
        else if (r.config_reg == `DTRCP_CFG_16)
        begin
            for (int i = 0; i < 2; i++)
            begin
                dec = r.cnt[i] - `DTRCP_CNT_W'(1);
                if (is_ecnt[i])
                begin
                    if (run[i] && ev[i])
                    begin
                        if (dec == r.counter_match_reg[i])
                        begin
                            next_r.cnt[i] = r.interval_load_reg[i];
                            next_r.control_reg[i].counter_enable = 1'b0;
                            set_f[i].count_match_flag = 1'b1;
                        end
                        else
                        begin
                            next_r.cnt[i] = dec;
                        end
                    end
                end
                else if (run[i] && is_timer[i])
                begin
                    if (r.ps[i] != '0)
                    begin
                        next_r.ps[i] = r.ps[i] - `DTRCP_PRE_W'(1);
                    end
                    else if (r.cnt[i] == '0)
                    begin
                        next_r.cnt[i] = r.interval_load_reg[i];
                        next_r.ps[i] = r.prescale_reg[i];
                        set_f[i].timeout_flag = 1'b1;
                        next_r.adc_trig[i] = r.control_reg[i].adc_trigger_enable;
                        if (r.counter_mode_reg[i].timer_mode_field == `DTRCP_TMR_ONESHOT)
                        begin
                            next_r.control_reg[i].counter_enable = 1'b0;
                        end
                    end
                    else
                    begin
                        next_r.cnt[i] = dec;
                        next_r.ps[i] = r.prescale_reg[i];
                    end
                end
                else if (run[i] && (is_etime[i] || is_pwm[i]))
                begin
                    next_r.cnt[i] = (r.cnt[i] == '0) ? r.interval_load_reg[i] : dec;
                    if (is_etime[i] && ev[i])
                    begin
                        next_r.captured_value_reg[i] = r.cnt[i];
                        set_f[i].capture_event_flag = 1'b1;
                    end
                    if (is_pwm[i] && r.cnt[i] == r.interval_load_reg[i])
                        next_r.pwm[i] = 1'b1;
                    else if (is_pwm[i] && r.cnt[i] == r.counter_match_reg[i])
                        next_r.pwm[i] = 1'b0;
                end
                // A running edge counter keeps its count; elsewhere the load lands next cycle.
                if (ilr_wr[i] && !(is_ecnt[i] && r.control_reg[i].counter_enable))
                begin
                    next_r.cnt[i] = wdata[`DTRCP_CNT_W-1:0];
                    next_r.ps[i] = r.prescale_reg[i];
                end
                next_r.pin_out[i] = next_r.pwm[i] ^ r.control_reg[i].pwm_invert_bit;
                next_r.pin_oe_n[i] = !is_pwm[i];
            end
        end
        if (r.config_reg != `DTRCP_CFG_16)
            next_r.pin_oe_n = '1;

        if (wr_stb)
        begin
            unique case (addr)
                `DTRCP_A_CFG:
                begin
                    next_r.config_reg = wdata[`DTRCP_CFG_W-1:0];
                    if (wdata[`DTRCP_CFG_W-1:0] == `DTRCP_CFG_RTC && !r.rtc_seen)
                    begin
                        next_r.cnt = `DTRCP_RTC_PRELOAD;
                        next_r.rtc_seen = 1'b1;
                        next_r.div = '0;
                    end
                end
                `DTRCP_A_MODE_A:
                    next_r.counter_mode_reg[0] = dtrcp_mode_t'(wdata[7:0] & `DTRCP_MODE_MASK);
                `DTRCP_A_MODE_B:
                    next_r.counter_mode_reg[1] = dtrcp_mode_t'(wdata[7:0] & `DTRCP_MODE_MASK);
                `DTRCP_A_CTL:
                    next_r.control_reg = wdata[15:0] & `DTRCP_CTL_MASK;
                `DTRCP_A_IMR:
                    next_r.interrupt_mask_reg = wdata[15:0] & {2{`DTRCP_STAT_MASK}};
                `DTRCP_A_ICR:
                    clr_f = wdata[15:0] & {2{`DTRCP_STAT_MASK}};
                `DTRCP_A_ILR_A:
                    next_r.interval_load_reg[0] = wdata[`DTRCP_CNT_W-1:0];
                `DTRCP_A_ILR_B:
                    next_r.interval_load_reg[1] = wdata[`DTRCP_CNT_W-1:0];
                `DTRCP_A_MATCH_A:
                    next_r.counter_match_reg[0] = wdata[`DTRCP_CNT_W-1:0];
                `DTRCP_A_MATCH_B:
                    next_r.counter_match_reg[1] = wdata[`DTRCP_CNT_W-1:0];
                `DTRCP_A_PR_A:
                    next_r.prescale_reg[0] = wdata[`DTRCP_PRE_W-1:0];
                `DTRCP_A_PR_B:
                    next_r.prescale_reg[1] = wdata[`DTRCP_PRE_W-1:0];
                default:
                    next_r.rdata = '0;
            endcase
        end

        // A flag set in the cycle it is cleared stays set.
        next_r.raw_status_reg = (r.raw_status_reg & ~clr_f) | set_f;
        next_r.irq = |(next_r.raw_status_reg & next_r.interrupt_mask_reg);

        if (rd_stb)
        begin
            unique case (addr)
                `DTRCP_A_CFG: next_r.rdata = `DTRCP_DATA_W'(r.config_reg);
                `DTRCP_A_MODE_A: next_r.rdata = `DTRCP_DATA_W'(r.counter_mode_reg[0]);
                `DTRCP_A_MODE_B: next_r.rdata = `DTRCP_DATA_W'(r.counter_mode_reg[1]);
                `DTRCP_A_CTL: next_r.rdata = `DTRCP_DATA_W'(r.control_reg);
                `DTRCP_A_IMR: next_r.rdata = `DTRCP_DATA_W'(r.interrupt_mask_reg);
                `DTRCP_A_RIS: next_r.rdata = `DTRCP_DATA_W'(r.raw_status_reg);
                `DTRCP_A_MIS:
                    next_r.rdata = `DTRCP_DATA_W'(r.raw_status_reg & r.interrupt_mask_reg);
                `DTRCP_A_ILR_A: next_r.rdata = `DTRCP_DATA_W'(r.interval_load_reg[0]);
                `DTRCP_A_ILR_B: next_r.rdata = `DTRCP_DATA_W'(r.interval_load_reg[1]);
                `DTRCP_A_MATCH_A: next_r.rdata = `DTRCP_DATA_W'(r.counter_match_reg[0]);
                `DTRCP_A_MATCH_B: next_r.rdata = `DTRCP_DATA_W'(r.counter_match_reg[1]);
                `DTRCP_A_PR_A: next_r.rdata = `DTRCP_DATA_W'(r.prescale_reg[0]);
                `DTRCP_A_PR_B: next_r.rdata = `DTRCP_DATA_W'(r.prescale_reg[1]);
                // Outside 16-bit operation a stale edge-time mode must not hide the clock count.
                `DTRCP_A_VAL_A: next_r.rdata = `DTRCP_DATA_W'(
                    (is_etime[0] && r.config_reg == `DTRCP_CFG_16) ?
                    r.captured_value_reg[0] : r.cnt[0]);
                `DTRCP_A_VAL_B: next_r.rdata = `DTRCP_DATA_W'(
                    (is_etime[1] && r.config_reg == `DTRCP_CFG_16) ?
                    r.captured_value_reg[1] : r.cnt[1]);
                default: next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            r <= DTRCP_RST;
        else
            r <= next_r;
    end

    assign rdata = r.rdata;
    assign irq = r.irq;
    assign adc_trig = r.adc_trig;
    assign capture_compare_pin_out = r.pin_out;
    assign capture_compare_pin_oe_n = r.pin_oe_n;

    // Edge count and PWM checks watch counter B, clock checks the joined 32-bit count and the divider, the rest counter A; both share one loop body.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_quiet;
        !wr_stb;
    endsequence

    sequence s_oneshot_zero;
        r.config_reg == `DTRCP_CFG_16 && is_timer[0] && run[0] &&
        r.counter_mode_reg[0].timer_mode_field == `DTRCP_TMR_ONESHOT &&
        r.cnt[0] == '0 && r.ps[0] == '0;
    endsequence

    AST_RTC_FIRST: assert property (
        wr_stb && addr == `DTRCP_A_CFG && wdata[`DTRCP_CFG_W-1:0] == `DTRCP_CFG_RTC &&
        !r.rtc_seen |=> r.cnt == `DTRCP_RTC_PRELOAD && r.rtc_seen)
        else $error("clock mode did not preload one");

    AST_RTC_COUNT: assert property (
        (rtc_tick && r.cnt != r.counter_match_reg) and s_quiet
        |=> r.cnt == $past(r.cnt) + `DTRCP_RTC_PRELOAD)
        else $error("32-bit clock count did not step up");

    AST_RTC_ROLL: assert property (
        (rtc_tick && r.cnt == r.counter_match_reg) and s_quiet
        |=> r.cnt == '0 && r.raw_status_reg[0].rtc_flag)
        else $error("clock match did not roll over and flag");

    AST_RTC_DEBUG: assert property (
        (r.config_reg == `DTRCP_CFG_RTC && r.control_reg[0].counter_enable &&
        r.control_reg[0].rtc_run_in_debug_bit && dbg_halt &&
        dtrcp_edge(`DTRCP_EVT_POS, r.sync2[0], r.prev[0])) and s_quiet
        |=> r.div != $past(r.div))
        else $error("clock froze in debug halt");

    AST_PRESCALE: assert property (
        (r.config_reg == `DTRCP_CFG_16 && is_timer[0] && run[0] && r.ps[0] != '0) and s_quiet
        |=> $stable(r.cnt[0]) && r.ps[0] == $past(r.ps[0]) - `DTRCP_PRE_W'(1))
        else $error("prescaler did not hold the count");

    AST_ONESHOT: assert property (
        s_oneshot_zero ##0 s_quiet |=> !r.control_reg[0].counter_enable &&
        r.cnt[0] == r.interval_load_reg[0] && r.raw_status_reg[0].timeout_flag &&
        r.adc_trig[0] == $past(r.control_reg[0].adc_trigger_enable))
        else $error("one-shot end wrong");

    AST_TO_HOLD: assert property (
        r.raw_status_reg[0].timeout_flag && !(wr_stb && addr == `DTRCP_A_ICR)
        |=> r.raw_status_reg[0].timeout_flag)
        else $error("time-out flag lost");

    AST_ILR_LOAD: assert property (
        r.config_reg == `DTRCP_CFG_16 && is_timer[0] && wr_stb && addr == `DTRCP_A_ILR_A
        |=> r.cnt[0] == $past(wdata[`DTRCP_CNT_W-1:0]))
        else $error("interval load not taken next cycle");

    AST_STALL: assert property (
        (r.config_reg == `DTRCP_CFG_16 && r.control_reg[0].counter_enable &&
        r.control_reg[0].debug_stall_bit && dbg_halt) and s_quiet |=> $stable(r.cnt[0]))
        else $error("counter moved during debug halt");

    AST_ECNT_MATCH: assert property (
        (r.config_reg == `DTRCP_CFG_16 && is_ecnt[1] && run[1] && ev[1] &&
        r.cnt[1] - `DTRCP_CNT_W'(1) == r.counter_match_reg[1]) and s_quiet
        |=> !r.control_reg[1].counter_enable && r.raw_status_reg[1].count_match_flag &&
        r.cnt[1] == r.interval_load_reg[1])
        else $error("edge count match wrong");

    AST_ETIME_CAP: assert property (
        (r.config_reg == `DTRCP_CFG_16 && is_etime[0] && run[0] && ev[0]) and s_quiet
        |=> r.captured_value_reg[0] == $past(r.cnt[0]) &&
        r.raw_status_reg[0].capture_event_flag)
        else $error("edge time capture wrong");

    AST_PWM_QUIET: assert property (
        (r.config_reg == `DTRCP_CFG_16 && is_pwm[1] &&
        r.raw_status_reg[1][2:0] == 3'h0) and s_quiet |=> r.raw_status_reg[1][2:0] == 3'h0)
        else $error("PWM mode raised a flag");

endmodule : dtrcp_timer

/* dv/dtrcp_edge_src.sv */
/*
 Edge source for one capture pin: on request it toggles the pin a given
 number of times. Assumes core_clk from the bench; the level stands between bursts.
*/
`timescale 1ns/1ps
module dtrcp_edge_src
(
    // Clock and request.
    input wire logic core_clk,
    input wire logic req,
    input wire logic [7:0] n_tog,
    input wire logic [3:0] hold,
    // Pin side.
    output logic pin,
    output logic busy
);
    initial
    begin
        pin = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge core_clk);
            if (req)
            begin
                busy <= 1'b1;
                repeat (n_tog)
                begin
                    // Each level must stand at least two clocks.
                    repeat (hold) @(posedge core_clk);
                    pin <= ~pin;
                end
                repeat (hold) @(posedge core_clk);
                busy <= 1'b0;
            end
        end
    end
endmodule : dtrcp_edge_src

/* dv/test_dual_timer_rtc_capture_pwm.sv */
/*
 Testbench of the dual timer: register tasks, edge sources and a small model.
 Assumes the package, the map header and the timer module are compiled first.
*/
`timescale 1ns/1ps
module test_dual_timer_rtc_capture_pwm;
    import dtrcp_pkg::*;
    logic core_clk, sys_rst, wr_stb, rd_stb, dbg_halt, irq;
    logic [7:0] addr, n_tog;
    logic [31:0] wdata, rdata, d, d2, seed;
    logic [1:0] pin_in, pin_out, pin_oe_n, adc_trig, req, busy;
    logic [3:0] hold;
    int bad_count, n_checks, cyc, trig_n, cnt, en, flag, i;

    dtrcp_timer #(.RTC_DIV(4)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dbg_halt(dbg_halt),
        .capture_compare_pin_in(pin_in), .capture_compare_pin_out(pin_out),
        .capture_compare_pin_oe_n(pin_oe_n), .irq(irq), .adc_trig(adc_trig));
    dtrcp_edge_src u_src0 (.core_clk(core_clk), .req(req[0]), .n_tog(n_tog), .hold(hold),
        .pin(pin_in[0]), .busy(busy[0]));
    dtrcp_edge_src u_src1 (.core_clk(core_clk), .req(req[1]), .n_tog(n_tog), .hold(hold),
        .pin(pin_in[1]), .busy(busy[1]));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // The run is about three hundred cycles; the ceiling leaves ample margin.
    always @(posedge core_clk)
    begin
        cyc++;
        if (!sys_rst && adc_trig[0] === 1'b1)
            trig_n++;
        if (cyc == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic c(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : c

    task automatic w(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : w

    task automatic r(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask : r

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift

    task automatic tog(input int p, input logic [7:0] n);
        seed = xorshift(seed);
        @(posedge core_clk);
        hold <= 4'h2 + {2'h0, seed[1:0]};
        n_tog <= n;
        req[p] <= 1'b1;
        @(posedge core_clk);
        req[p] <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 300 && busy[p] !== 1'b0; k++)
            @(posedge core_clk);
        // Two synchroniser flops, the compare and the update.
        repeat (6) @(posedge core_clk);
    endtask : tog

    initial
    begin
        {sys_rst, wr_stb, rd_stb, dbg_halt, req, addr, wdata, n_tog} = '0;
        sys_rst = 1'b1;
        hold = 4'h2;
        seed = 32'hD3AC0F4E;
        {bad_count, n_checks, cyc, trig_n} = '0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        r(8'h48);
        c("count_a", 32'h0000FFFF, d);
        r(8'h40);
        c("unmapped", 32'h0, d);
        w(8'h00, 32'h4);
        r(8'h00);
        c("config", 32'h4, d);
        w(8'h04, 32'h1);
        w(8'h38, 32'h3);
        w(8'h28, 32'h8);
        w(8'h18, 32'h1);
        w(8'h0C, 32'h21);
        for (i = 0; i < 40; i++)
        begin
            r(8'h1C);
            if (d[0] === 1'b1)
                break;
        end
        c("timeout_raw", 32'h1, {31'h0, d[0]});
        c("prescaled_wait", 32'h1, {31'h0, i >= 12 && i <= 22});
        r(8'h0C);
        c("oneshot_enable", 32'h0, {31'h0, d[0]});
        c("adc_pulses", 32'h1, trig_n);
        c("irq_set", 32'h1, {31'h0, irq});
        w(8'h24, 32'h1);
        r(8'h1C);
        c("timeout_clear", 32'h0, {31'h0, d[0]});
        w(8'h08, 32'h3);
        w(8'h2C, 32'hA);
        w(8'h34, 32'h6);
        w(8'h0C, 32'h0900);
        {cnt, en, flag} = {32'd10, 32'd1, 32'd0};
        for (int k = 0; k < 6; k++)
            if (en == 1)
            begin
                cnt--;
                if (cnt == 6)
                    {flag, cnt, en} = {32'd1, 32'd10, 32'd0};
            end
        tog(1, 8'h6);
        r(8'h1C);
        c("match_flag", flag, {31'h0, d[9]});
        r(8'h4C);
        c("count_b", cnt, d);
        r(8'h0C);
        c("count_enable", en, {31'h0, d[8]});
        w(8'h24, 32'h0F0F);
        w(8'h28, 32'hFFFF);
        w(8'h04, 32'h7);
        w(8'h0C, 32'h1);
        tog(0, 8'h2);
        r(8'h48);
        d2 = d;
        r(8'h48);
        c("capture_hold", d2, d);
        r(8'h1C);
        c("event_flag", 32'h1, {31'h0, d[2]});
        tog(0, 8'h2);
        r(8'h48);
        c("recapture", 32'h1, {31'h0, d < d2});
        d2 = d;
        w(8'h0C, 32'h3);
        dbg_halt <= 1'b1;
        tog(0, 8'h2);
        r(8'h48);
        c("stall_capture", d2, d);
        @(posedge core_clk);
        dbg_halt <= 1'b0;
        w(8'h08, 32'hA);
        w(8'h0C, 32'h0100);
        repeat (3) @(negedge core_clk);
        c("pwm_drive", 32'h0, {31'h0, pin_oe_n[1]});
        r(8'h1C);
        c("pwm_flags", 32'h0, {24'h0, d[15:8]});
        cnt = 0;
        repeat (22)
        begin
            @(negedge core_clk);
            cnt += (pin_out[1] === 1'b1);
        end
        c("pwm_high", 32'h8, cnt);
        w(8'h0C, 32'h0);
        w(8'h00, 32'h1);
        r(8'h48);
        c("preload_lo", 32'h1, d);
        r(8'h4C);
        c("preload_hi", 32'h0, d);
        w(8'h30, 32'h2);
        w(8'h34, 32'h0);
        w(8'h18, 32'h8);
        @(posedge core_clk);
        dbg_halt <= 1'b1;
        w(8'h0C, 32'h13);
        tog(0, 8'h10);
        r(8'h1C);
        c("rtc_flag", 32'h1, {31'h0, d[3]});
        c("rtc_irq", 32'h1, {31'h0, irq});
        r(8'h48);
        c("rtc_roll", 32'h0, d);
        w(8'h24, 32'h8);
        r(8'h1C);
        c("rtc_clear", 32'h0, {31'h0, d[3]});
        wrap_up();
    end
endmodule : test_dual_timer_rtc_capture_pwm
